// [design/ldc_params.svh]
// Register indices, field positions, reset values and peak arithmetic constants
`ifndef LDC_PARAMS_SVH
`define LDC_PARAMS_SVH

// Register indices; byte address is four times the index
`define LDC_IDX_SLOT_CTRL   8'h14
`define LDC_IDX_THIRD_CFG   8'h22
`define LDC_IDX_FINE_TRIM   8'h25
`define LDC_IDX_PEAK        8'h30
`define LDC_IDX_W           8

// Reset values
`define LDC_RST_SLOT_CTRL   16'h0541
`define LDC_RST_THIRD_CFG   16'h3000
`define LDC_RST_FINE_TRIM   16'h0000

// Field positions
`define LDC_SEL_MSB         1
`define LDC_SEL_LSB         0
`define LDC_STRENGTH_BIT    13
`define LDC_EDGE_MSB        6
`define LDC_EDGE_LSB        4
`define LDC_COARSE_MSB      3
`define LDC_COARSE_LSB      0
`define LDC_FINE_MSB        15
`define LDC_FINE_LSB        11

// Emitter select codes
`define LDC_SEL_NONE        2'h0
`define LDC_SEL_ONE         2'h1
`define LDC_SEL_TWO         2'h2
`define LDC_SEL_THREE       2'h3

// Peak terms: coarse in 1/100 mA, fine in 1/1000, scale in 1/10
`define LDC_COARSE_BASE     32'h0000_0af0
`define LDC_COARSE_STEP     32'h0000_060a
`define LDC_FINE_BASE       32'h0000_02c6
`define LDC_FINE_STEP       32'h0000_0018
`define LDC_SCALE_LOW       32'h0000_0004
`define LDC_SCALE_ADD       32'h0000_0006

// Bus encodings
`define LDC_HSIZE_WORD      3'h2
`define LDC_HTRANS_ACT_BIT  1
`define LDC_RESP_OKAY       1'b0
`define LDC_MIN_ADDR_W      11

`endif

// [design/ldc_pkg.sv]
// Types shared by the LED drive current configuration block
package ldc_pkg;
  typedef logic [15:0] ldc_reg16_t;
  typedef logic [31:0] ldc_peak_t;
  typedef enum logic [1:0] {LDC_IDLE, LDC_WRITE, LDC_READ, LDC_READ_OUT} ldc_bus_state_t;
endpackage

// [design/ldc_reg_if.sv]
// Register access carrier between bus slave and register bank
`timescale 1ns/100ps
`default_nettype none
interface ldc_reg_if;
  logic        wr_en;
  logic [7:0]  index;
  logic [15:0] wdata;
  logic [31:0] rdata;
  modport slave (output wr_en, output index, output wdata, input rdata);
  modport regs  (input wr_en, input index, input wdata, output rdata);
endinterface
`default_nettype wire

// [design/ldc_ahb_slave.sv]
// AHB-Lite slave: zero-wait writes, one-wait reads
`timescale 1ns/100ps
`default_nettype none
`include "ldc_params.svh"
module ldc_ahb_slave
#(
  parameter int ADDR_W = 12
)
(
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Register side
  ldc_reg_if.slave               regs
);
  import ldc_pkg::*;

  if (ADDR_W < `LDC_MIN_ADDR_W)
    $error("ldc_ahb_slave: ADDR_W too small");

  ldc_bus_state_t state;
  ldc_bus_state_t next_state;
  logic [7:0]     index_q;
  logic           ok_q;

  ////////////////////////////////////////////////////////////////////////
  // Address phase decode; misaligned, narrow or high addresses are unmapped
  wire accept  = hsel && htrans[`LDC_HTRANS_ACT_BIT] && hready;
  wire addr_ok = (haddr[1:0] == 2'h0) && (hsize == `LDC_HSIZE_WORD)
                 && (haddr[ADDR_W-1:10] == '0);

  always_comb
  begin
    next_state = state;
    case (state)
      LDC_READ:
        next_state = LDC_READ_OUT;
      LDC_IDLE, LDC_WRITE, LDC_READ_OUT:
        if (accept)
          next_state = hwrite ? LDC_WRITE : LDC_READ;
        else
          next_state = LDC_IDLE;
      default:
        next_state = LDC_IDLE;
    endcase
  end

  // Phase state and captured address
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state   <= LDC_IDLE;
      index_q <= 8'h00;
      ok_q    <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (accept && state != LDC_READ)
      begin
        index_q <= haddr[9:2];
        ok_q    <= addr_ok;
      end
    end
  end

  // Read data latched in the wait cycle so a write just before is seen
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (state == LDC_READ)
      hrdata <= ok_q ? regs.rdata : 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register strobes; upper write lanes are dropped
  assign regs.wr_en  = (state == LDC_WRITE) && ok_q;
  assign regs.index  = index_q;
  assign regs.wdata  = hwdata[15:0];
  assign hreadyout   = (state != LDC_READ);
  assign hresp       = `LDC_RESP_OKAY;
endmodule
`default_nettype wire

// [design/ldc_peak_calc.sv]
// Peak current target arithmetic for the third driver
`timescale 1ns/100ps
`default_nettype none
`include "ldc_params.svh"
module ldc_peak_calc
(
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Settings
  input  wire logic [3:0]       coarse_code,
  input  wire logic [4:0]       fine_code,
  input  wire logic             strength,
  // Result in nanoamperes (mA x 1e6)
  output ldc_pkg::ldc_peak_t    peak
);
  import ldc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Scaled integer terms keep the product exact; max fits in 29 bits
  wire [31:0] third_coarse_term    = `LDC_COARSE_BASE + `LDC_COARSE_STEP * {28'h0, coarse_code};
  wire [31:0] third_fine_trim_term = `LDC_FINE_BASE + `LDC_FINE_STEP * {27'h0, fine_code};
  wire [31:0] third_scale_factor   = `LDC_SCALE_LOW + `LDC_SCALE_ADD * {31'h0, strength};
  wire [31:0] next_peak = third_coarse_term * third_fine_trim_term * third_scale_factor;

  // Registered so the multiplier is off the bus timing path
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      peak <= 32'h0000_0000;
    else
      peak <= next_peak;
  end
endmodule
`default_nettype wire

// [design/ldc_top.sv]
// LED drive current configuration bank with slot emitter selection
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ldc_params.svh"
module ldc_top
#(
  parameter int ADDR_W = 12
)
(
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // First time slot window from the sequencer pin
  input  wire logic              first_slot_active,
  // Emitter pulse outputs
  output logic                   emitter_output_one,
  output logic                   emitter_output_two,
  output logic                   emitter_output_three,
  // Third driver settings
  output logic                   third_driver_strength_select,
  output logic      [2:0]        third_driver_edge_rate,
  output logic      [3:0]        third_driver_coarse_target,
  output logic      [4:0]        third_fine_trim_code,
  output ldc_pkg::ldc_peak_t     third_peak_current_target
);
  import ldc_pkg::*;

  ldc_reg_if  bus_if ();
  ldc_reg16_t slot_ctrl;
  ldc_reg16_t third_cfg;
  ldc_reg16_t fine_trim;
  logic       slot_sync1;
  logic       slot_sync2;
  logic       slot_sync3;
  logic       slot_level;

  ////////////////////////////////////////////////////////////////////////
  // Bus slave
  ldc_ahb_slave #(.ADDR_W(ADDR_W)) u_slave
  (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .regs      (bus_if.slave)
  );

  ////////////////////////////////////////////////////////////////////////
  // Write decode
  wire wr_slot  = bus_if.wr_en && (bus_if.index == `LDC_IDX_SLOT_CTRL);
  wire wr_cfg   = bus_if.wr_en && (bus_if.index == `LDC_IDX_THIRD_CFG);
  wire wr_fine  = bus_if.wr_en && (bus_if.index == `LDC_IDX_FINE_TRIM);

  // Reserved bits are kept as written; the driver ignores them
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      slot_ctrl <= `LDC_RST_SLOT_CTRL;
      third_cfg <= `LDC_RST_THIRD_CFG;
      fine_trim <= `LDC_RST_FINE_TRIM;
    end
    else
    begin
      if (wr_slot)
        slot_ctrl <= bus_if.wdata;
      if (wr_cfg)
        third_cfg <= bus_if.wdata;
      if (wr_fine)
        fine_trim <= bus_if.wdata;
    end
  end

  // Read mux; unmapped words read as zero
  wire sel_slot = (bus_if.index == `LDC_IDX_SLOT_CTRL);
  wire sel_cfg  = (bus_if.index == `LDC_IDX_THIRD_CFG);
  wire sel_fine = (bus_if.index == `LDC_IDX_FINE_TRIM);
  wire sel_peak = (bus_if.index == `LDC_IDX_PEAK);
  assign bus_if.rdata = sel_slot ? {16'h0000, slot_ctrl} :
                        sel_cfg  ? {16'h0000, third_cfg} :
                        sel_fine ? {16'h0000, fine_trim} :
                        sel_peak ? third_peak_current_target :
                                   32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  // Driver fields straight from the register flops
  assign third_driver_strength_select = third_cfg[`LDC_STRENGTH_BIT];
  assign third_driver_edge_rate = third_cfg[`LDC_EDGE_MSB:`LDC_EDGE_LSB];
  assign third_driver_coarse_target = third_cfg[`LDC_COARSE_MSB:`LDC_COARSE_LSB];
  assign third_fine_trim_code = fine_trim[`LDC_FINE_MSB:`LDC_FINE_LSB];

  // Peak target; bits are outside every field so cannot skew it
  ldc_peak_calc u_peak
  (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .coarse_code (third_driver_coarse_target),
    .fine_code   (third_fine_trim_code),
    .strength    (third_driver_strength_select),
    .peak        (third_peak_current_target)
  );

  ////////////////////////////////////////////////////////////////////////
  // Slot pin synchroniser; level changes only when stages two and three agree
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      slot_sync1 <= 1'b0;
      slot_sync2 <= 1'b0;
      slot_sync3 <= 1'b0;
      slot_level <= 1'b0;
    end
    else
    begin
      slot_sync1 <= first_slot_active;
      slot_sync2 <= slot_sync1;
      slot_sync3 <= slot_sync2;
      if (slot_sync2 == slot_sync3)
        slot_level <= slot_sync3;
    end
  end

  // Emitter selection; reserved code 0 fires nothing
  wire [1:0] first_slot_emitter_select = slot_ctrl[`LDC_SEL_MSB:`LDC_SEL_LSB];
  wire next_emit_one   = slot_level && (first_slot_emitter_select == `LDC_SEL_ONE);
  wire next_emit_two   = slot_level && (first_slot_emitter_select == `LDC_SEL_TWO);
  wire next_emit_three = slot_level && (first_slot_emitter_select == `LDC_SEL_THREE);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      emitter_output_one   <= 1'b0;
      emitter_output_two   <= 1'b0;
      emitter_output_three <= 1'b0;
    end
    else
    begin
      emitter_output_one   <= next_emit_one;
      emitter_output_two   <= next_emit_two;
      emitter_output_three <= next_emit_three;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks: reference terms written independently of the calculator
  wire [31:0] chk_coarse = `LDC_COARSE_BASE + `LDC_COARSE_STEP * {28'h0, third_cfg[3:0]};
  wire [31:0] chk_fine   = `LDC_FINE_BASE + `LDC_FINE_STEP * {27'h0, fine_trim[15:11]};
  wire [31:0] chk_full   = (`LDC_SCALE_LOW + `LDC_SCALE_ADD);
  wire [31:0] chk_scale  = third_cfg[13] ? chk_full : `LDC_SCALE_LOW;
  ldc_reg16_t prev_cfg;
  ldc_reg16_t prev_fine;
  logic       past_valid;

  // Previous settings; the peak lags one cycle, so checks wait for a settled cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_cfg   <= `LDC_RST_THIRD_CFG;
      prev_fine  <= `LDC_RST_FINE_TRIM;
      past_valid <= 1'b0;
    end
    else
    begin
      prev_cfg   <= third_cfg;
      prev_fine  <= fine_trim;
      past_valid <= 1'b1;
    end
  end

  wire cfg_steady = past_valid && (prev_cfg == third_cfg) && (prev_fine == fine_trim);

  default clocking chk_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  emit_one_a: assert property (slot_level && slot_ctrl[1:0] == `LDC_SEL_ONE
    |=> emitter_output_one && !emitter_output_two && !emitter_output_three)
    else $error("emitter one not pulsed for code 1");
  emit_two_a: assert property (slot_level && slot_ctrl[1:0] == `LDC_SEL_TWO
    |=> emitter_output_two && !emitter_output_one && !emitter_output_three)
    else $error("emitter two not pulsed for code 2");
  emit_three_a: assert property (slot_level && slot_ctrl[1:0] == `LDC_SEL_THREE
    |=> emitter_output_three && !emitter_output_one && !emitter_output_two)
    else $error("emitter three not pulsed for code 3");
  sel_reserved_a: assert property (!slot_level || slot_ctrl[1:0] == `LDC_SEL_NONE
    |=> !(emitter_output_one || emitter_output_two || emitter_output_three))
    else $error("emitter pulsed outside slot or for reserved code");
  strength_wr_a: assert property (wr_cfg
    |=> third_driver_strength_select == $past(bus_if.wdata[13]))
    else $error("strength select does not follow bit 13");
  scale_only_a: assert property (cfg_steady && third_cfg[3:0] == 4'h0
    && fine_trim[15:11] == 5'h00
    |-> third_peak_current_target == `LDC_COARSE_BASE * `LDC_FINE_BASE * chk_scale)
    else $error("scale factor wrong");
  edge_wr_a: assert property (wr_cfg ##1 1'b1
    |-> third_driver_edge_rate == $past(bus_if.wdata[6:4]))
    else $error("edge rate does not follow bits 6:4");
  coarse_wr_a: assert property (wr_cfg
    |=> third_driver_coarse_target == $past(bus_if.wdata[3:0]))
    else $error("coarse target does not follow bits 3:0");
  coarse_term_a: assert property (cfg_steady && third_cfg[13] && fine_trim[15:11] == 5'h00
    |-> third_peak_current_target == chk_coarse * `LDC_FINE_BASE * chk_full)
    else $error("coarse term wrong");
  fine_term_a: assert property (cfg_steady && third_cfg[13] && third_cfg[3:0] == 4'h0
    |-> third_peak_current_target == `LDC_COARSE_BASE * chk_fine * chk_full)
    else $error("fine term wrong");
  peak_prod_a: assert property (cfg_steady
    |-> third_peak_current_target == chk_coarse * chk_fine * chk_scale)
    else $error("peak target is not the product of its terms");
  readback_a: assert property (wr_cfg |=> third_cfg == $past(bus_if.wdata))
    else $error("config write not held");
  trim_store_a: assert property (wr_fine |=> fine_trim == $past(bus_if.wdata))
    else $error("fine trim write not held");
  slot_store_a: assert property (wr_slot |=> slot_ctrl == $past(bus_if.wdata))
    else $error("slot control write not held");
  cfg_hold_a: assert property (!wr_cfg |=> $stable(third_cfg))
    else $error("config changed without a write");

  cov_emit_three_c: cover property (slot_level && slot_ctrl[1:0] == `LDC_SEL_THREE
    ##1 emitter_output_three);
  cov_low_power_c: cover property (wr_cfg && !bus_if.wdata[13] ##2 !third_driver_strength_select);
  cov_peak_read_c: cover property (bus_if.index == `LDC_IDX_PEAK && hreadyout == 1'b0);
endmodule
`default_nettype wire

// [testbench/ldc_testbench.sv]
// Self-checking bench for the LED drive current configuration bank
`timescale 1ns/100ps
`default_nettype none
`include "ldc_params.svh"
module testbench;
  import ldc_pkg::*;
  // Row of the ordinary-case table
  typedef struct {
    ldc_reg16_t cfg;
    ldc_reg16_t trim;
    logic       s;
    logic [2:0] e;
    logic [3:0] c;
    logic [4:0] f;
  } ldc_tb_row_t;
  // Bus, pins and bookkeeping
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        slot;
  logic        em1;
  logic        em2;
  logic        em3;
  logic        strength;
  logic [2:0]  edge_rate;
  logic [3:0]  coarse;
  logic [4:0]  fine;
  ldc_peak_t   peak;
  logic [31:0] rd;
  int          err_total;
  int          total_checks;
  // Writes keep bit 12 set and the other reserved bits clear
  ldc_tb_row_t rows [4] = '{
    '{16'h3000, 16'h0000, 1'b1, 3'h0, 4'h0, 5'h00},
    '{16'h107f, 16'hf800, 1'b0, 3'h7, 4'hf, 5'h1f},
    '{16'h305a, 16'h5000, 1'b1, 3'h5, 4'ha, 5'h0a},
    '{16'h1021, 16'h0800, 1'b0, 3'h2, 4'h1, 5'h01}};

  ////////////////////////////////////////////////////////////////////////////
  ldc_top u_dut (
    .hclk                         (hclk),
    .hresetn                      (hresetn),
    .hsel                         (hsel),
    .haddr                        (haddr),
    .htrans                       (htrans),
    .hwrite                       (hwrite),
    .hsize                        (hsize),
    .hwdata                       (hwdata),
    .hready                       (hreadyout),
    .hrdata                       (hrdata),
    .hreadyout                    (hreadyout),
    .hresp                        (hresp),
    .first_slot_active            (slot),
    .emitter_output_one           (em1),
    .emitter_output_two           (em2),
    .emitter_output_three         (em3),
    .third_driver_strength_select (strength),
    .third_driver_edge_rate       (edge_rate),
    .third_driver_coarse_target   (coarse),
    .third_fine_trim_code         (fine),
    .third_peak_current_target    (peak)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 5 ns period
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // Byte address of a register index
  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  // Peak in nA, integer form of coarse x fine x scale
  function automatic ldc_peak_t peak_of(input ldc_reg16_t cfg, input ldc_reg16_t trim);
    return (32'd2800 + 32'd1546 * cfg[3:0]) * (32'd710 + 32'd24 * trim[15:11])
           * (32'd4 + 32'd6 * cfg[13]);
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Ready is sampled at the rising edge that completes the phase
  task automatic wait_ready();
    int n;
    n = 0;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    if (n >= 50)
      chk("hready wait", 32'h0, 32'h1);
  endtask

  // One single-word transfer; read data is taken at the completing edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    chk("hresp", 32'(hresp), 32'h0);
  endtask

  task automatic check_fields(input ldc_reg16_t cfg, input ldc_reg16_t trim);
    repeat (2) @(posedge hclk);
    chk("strength", 32'(strength), 32'(cfg[13]));
    chk("edge rate", 32'(edge_rate), 32'(cfg[6:4]));
    chk("coarse", 32'(coarse), 32'(cfg[3:0]));
    chk("fine", 32'(fine), 32'(trim[15:11]));
    chk("peak", peak, peak_of(cfg, trim));
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the fewer than two hundred cycles the tests need
  initial
  begin
    #50000;
    err_total++;
    give_verdict();
  end

  // Main sequence
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    slot = 1'b0;
    err_total = 0;
    total_checks = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values through the bus and at the ports
    check_fields(`LDC_RST_THIRD_CFG, `LDC_RST_FINE_TRIM);
    xfer(1'b0, ad(`LDC_IDX_SLOT_CTRL), 32'h0);
    chk("slot reg reset", rd, 32'h0000_0541);
    xfer(1'b0, ad(`LDC_IDX_THIRD_CFG), 32'h0);
    chk("cfg reset", rd, 32'h0000_3000);
    xfer(1'b0, ad(`LDC_IDX_FINE_TRIM), 32'h0);
    chk("trim reset", rd, 32'h0000_0000);
    $display("test reset values done");
    // Ordinary cases from the table
    foreach (rows[i])
    begin
      xfer(1'b1, ad(`LDC_IDX_THIRD_CFG), {16'habcd, rows[i].cfg});
      xfer(1'b1, ad(`LDC_IDX_FINE_TRIM), {16'h1234, rows[i].trim});
      check_fields(rows[i].cfg, rows[i].trim);
      chk("row strength", 32'(strength), 32'(rows[i].s));
      chk("row edge", 32'(edge_rate), 32'(rows[i].e));
      chk("row coarse", 32'(coarse), 32'(rows[i].c));
      chk("row fine", 32'(fine), 32'(rows[i].f));
      xfer(1'b0, ad(`LDC_IDX_THIRD_CFG), 32'h0);
      chk("cfg readback", rd, {16'h0, rows[i].cfg});
      xfer(1'b0, ad(`LDC_IDX_FINE_TRIM), 32'h0);
      chk("trim readback", rd, {16'h0, rows[i].trim});
      xfer(1'b0, ad(`LDC_IDX_PEAK), 32'h0);
      chk("peak readback", rd, peak_of(rows[i].cfg, rows[i].trim));
    end
    $display("test table done");
    // Every select code, the reserved code 0 included
    for (int k = 0; k < 4; k++)
    begin
      xfer(1'b1, ad(`LDC_IDX_SLOT_CTRL), 32'h0540 | 32'(k));
      slot <= 1'b1;
      repeat (8) @(posedge hclk);
      chk("emitters on", 32'({em3, em2, em1}), 32'(k == 0 ? 3'h0 : 3'h1 << (k - 1)));
      slot <= 1'b0;
      repeat (8) @(posedge hclk);
      chk("emitters off", 32'({em3, em2, em1}), 32'h0);
    end
    $display("test slot select done");
    // Unmapped accesses neither store nor return anything
    xfer(1'b1, 12'h400 | ad(`LDC_IDX_THIRD_CFG), 32'h0000_3077);
    xfer(1'b0, 12'h400 | ad(`LDC_IDX_THIRD_CFG), 32'h0);
    chk("unmapped read", rd, 32'h0);
    xfer(1'b0, ad(`LDC_IDX_THIRD_CFG), 32'h0);
    chk("cfg untouched", rd, {16'h0, rows[3].cfg});
    $display("test unmapped done");
    // Reset in mid-run brings every field back at once
    @(posedge hclk);
    hresetn <= 1'b0;
    #1;
    chk("reset strength", 32'(strength), 32'h1);
    chk("reset coarse", 32'({edge_rate, coarse, fine}), 32'h0);
    chk("reset peak", peak, 32'h0);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    check_fields(`LDC_RST_THIRD_CFG, `LDC_RST_FINE_TRIM);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
